// ===== hw/pvr_params.svh
// constants shared by both ends of the pin verify link
`ifndef PVR_PARAMS_SVH
`define PVR_PARAMS_SVH

// command header coding
`define PVR_CLA_BASE 8'h00
`define PVR_INS_VERIFY 8'h20
`define PVR_P1_VERIFY 8'h00
`define PVR_LC_PIN 8'h08
`define PVR_PIN_BYTES 4'h8

// byte positions in a command
`define PVR_POS_CLA 4'h0
`define PVR_POS_INS 4'h1
`define PVR_POS_P1 4'h2
`define PVR_POS_P2 4'h3
`define PVR_POS_LC 4'h4
`define PVR_POS_DATA 4'h5
`define PVR_HDR_BYTES 4'h4
`define PVR_FULL_BYTES 4'hd
`define PVR_CNT_MAX 4'hf

// P2 field positions
`define PVR_P2_CLASS 7
`define PVR_P2_RFU_HI 6
`define PVR_P2_RFU_LO 5
`define PVR_P2_REF_HI 4

// retry counter
`define PVR_TRIES_INIT 2'h3
`define PVR_TRIES_NONE 2'h0

// status words
`define PVR_SW_OK 16'h9000
`define PVR_SW_RETRY 12'h63c
`define PVR_SW_BLOCKED 16'h6983
`define PVR_SW_DISABLED 16'h6984
`define PVR_SW_WRONG_LEN 16'h6700
`define PVR_SW_WRONG_P1 16'h6b00
`define PVR_SW_WRONG_P2 16'h6a86
`define PVR_SW_NOT_FOUND 16'h6a88
`define PVR_SW_BAD_INS 16'h6d00

`endif

// ===== hw/pvr_pkg.sv
// types shared by both ends of the pin verify link
package pvr_pkg;

  typedef enum logic [0:0] {
    PVR_CS_RX = 1'b0,
    PVR_CS_EXEC = 1'b1
  } pvr_card_state_t;

  typedef enum logic [1:0] {
    PVR_TS_IDLE = 2'b00,
    PVR_TS_SEND = 2'b01,
    PVR_TS_WAIT = 2'b10
  } pvr_term_state_t;

endpackage

// ===== hw/pvr_if.sv
// link between terminal and card: command bytes in, status word out
`timescale 1ns/1ps
`default_nettype none
interface pvr_if;
  logic byte_valid;
  logic [7:0] byte_data;
  logic byte_last;
  logic sw_valid;
  logic [15:0] sw;

  modport card (
    input byte_valid,
    input byte_data,
    input byte_last,
    output sw_valid,
    output sw
  );

  modport term (
    output byte_valid,
    output byte_data,
    output byte_last,
    input sw_valid,
    input sw
  );
endinterface
`default_nettype wire

// ===== hw/pvr_card.sv
// card end: pin verify command, retry counters, security status
`timescale 1ns/1ps
`default_nettype none
`include "pvr_params.svh"

// How it works
// - compare only if pin enabled and unblocked
// - correct pin restores counter to three
// - wrong pin decrements counter, any channel
// - security status shared by all channels
// - first wrong pin answers 63C2
// - second wrong pin answers 63C1
// - counters survive sessions, only power reset
// - third wrong pin blocks, answers 63C0
// - data to blocked pin answers 6983
// - blocked pin unmet until unblocked, unless disabled
// - pin access needs verify unless disabled
// - empty data reports counter, never compares
// - query answers 63CX, X tries left
// - terminal queries with P2, no data
// - P1 00, no Le, Lc empty/08
// - P2 b8 picks global or specific
// - P2 b7 b6 nonzero is refused
// - P2 low five bits key reference
module pvr_card #(
  parameter int KW = 1
) (
  // clock and power-on reset
  input wire logic clk,
  input wire logic nrst,
  // link to terminal
  pvr_if.card lk,
  // session and administration
  input wire logic session_start,
  input wire logic [KW:0] adm_idx,
  input wire logic ref_we,
  input wire logic [63:0] ref_pin,
  input wire logic dis_set,
  input wire logic dis_clr,
  input wire logic unblock,
  // access check for file operations
  input wire logic acc_req,
  input wire logic [KW:0] acc_idx,
  output logic acc_ok
);

  localparam int NPIN = 2 ** (KW + 1);

  if (KW < 1 || KW > 4) begin : g_chk
    $error("pvr_card: KW must be 1 to 4");
  end

  ////////////////////////////////////////////////////////////////////////
  // command capture

  pvr_pkg::pvr_card_state_t state_reg;
  logic [3:0] cnt_reg;
  logic [7:0] ins_reg;
  logic [7:0] p1_reg;
  logic [7:0] p2_reg;
  logic [7:0] lc_reg;
  logic [63:0] data_reg;
  logic [15:0] sw_reg;
  logic sw_valid_reg;

  // byte counter saturates so overlong commands are still caught
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= 4'h0;
    end else if (state_reg == pvr_pkg::PVR_CS_EXEC) begin
      cnt_reg <= 4'h0;
    end else if (lk.byte_valid && cnt_reg != `PVR_CNT_MAX) begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end

  // header fields and pin data, msb byte first
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ins_reg <= 8'h00;
      p1_reg <= 8'h00;
      p2_reg <= 8'h00;
      lc_reg <= 8'h00;
      data_reg <= 64'h0;
    end else if (state_reg == pvr_pkg::PVR_CS_RX && lk.byte_valid) begin
      unique case (cnt_reg)
        `PVR_POS_CLA: begin
          lc_reg <= 8'h00; // channel bits are not needed here
        end
        `PVR_POS_INS: ins_reg <= lk.byte_data;
        `PVR_POS_P1: p1_reg <= lk.byte_data;
        `PVR_POS_P2: p2_reg <= lk.byte_data;
        `PVR_POS_LC: lc_reg <= lk.byte_data;
        default: data_reg <= {data_reg[55:0], lk.byte_data};
      endcase
    end
  end

  // receive until the last byte, then one cycle to execute
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= pvr_pkg::PVR_CS_RX;
    end else begin
      unique case (state_reg)
        pvr_pkg::PVR_CS_RX: begin
          if (lk.byte_valid && lk.byte_last) begin
            state_reg <= pvr_pkg::PVR_CS_EXEC;
          end
        end
        pvr_pkg::PVR_CS_EXEC: state_reg <= pvr_pkg::PVR_CS_RX;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // decode and judge

  logic [1:0] tries_reg [NPIN];
  logic [NPIN-1:0] verified_reg;
  logic [NPIN-1:0] disabled_reg;
  logic [63:0] ref_mem [NPIN];

  logic [KW:0] idx;
  logic has_lc;
  logic is_query;
  logic hit;
  logic miss;
  logic [1:0] tries_cur;
  logic [1:0] tries_dec;
  logic [15:0] sw_next;

  // b8 picks the class, low bits the key reference
  assign idx = {p2_reg[`PVR_P2_CLASS], p2_reg[KW-1:0]};
  assign has_lc = cnt_reg > `PVR_HDR_BYTES;
  assign is_query = !has_lc || (lc_reg == 8'h00 && cnt_reg == `PVR_POS_DATA);
  assign tries_cur = tries_reg[idx];
  assign tries_dec = tries_cur - 2'h1;

  // checks in priority order; only the last branches touch the pin
  always_comb begin
    hit = 1'b0;
    miss = 1'b0;
    if (cnt_reg < `PVR_HDR_BYTES) begin
      sw_next = `PVR_SW_WRONG_LEN;
    end else if (ins_reg != `PVR_INS_VERIFY) begin
      sw_next = `PVR_SW_BAD_INS;
    end else if (p1_reg != `PVR_P1_VERIFY) begin
      sw_next = `PVR_SW_WRONG_P1;
    end else if (p2_reg == 8'h00 || p2_reg[`PVR_P2_RFU_HI:`PVR_P2_RFU_LO] != 2'b00) begin
      sw_next = `PVR_SW_WRONG_P2;
    end else if (p2_reg[`PVR_P2_REF_HI:KW] != '0) begin
      sw_next = `PVR_SW_NOT_FOUND;
    end else if (is_query) begin
      sw_next = {`PVR_SW_RETRY, 2'b00, tries_cur};
    end else if (lc_reg != `PVR_LC_PIN || cnt_reg != `PVR_FULL_BYTES) begin
      sw_next = `PVR_SW_WRONG_LEN;
    end else if (tries_cur == `PVR_TRIES_NONE) begin
      sw_next = `PVR_SW_BLOCKED;
    end else if (disabled_reg[idx]) begin
      sw_next = `PVR_SW_DISABLED;
    end else if (data_reg == ref_mem[idx]) begin
      sw_next = `PVR_SW_OK;
      hit = 1'b1;
    end else begin
      sw_next = {`PVR_SW_RETRY, 2'b00, tries_dec};
      miss = 1'b1;
    end
  end

  // status word answer, one pulse per command
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sw_reg <= `PVR_SW_OK;
      sw_valid_reg <= 1'b0;
    end else begin
      sw_valid_reg <= state_reg == pvr_pkg::PVR_CS_EXEC;
      if (state_reg == pvr_pkg::PVR_CS_EXEC) begin
        sw_reg <= sw_next;
      end
    end
  end

  assign lk.sw = sw_reg;
  assign lk.sw_valid = sw_valid_reg;

  ////////////////////////////////////////////////////////////////////////
  // per-pin state

  logic exec;
  assign exec = state_reg == pvr_pkg::PVR_CS_EXEC;

  for (genvar i = 0; i < NPIN; i++) begin : g_pin
    logic cmd_here;
    logic adm_here;
    assign cmd_here = exec && idx == (KW+1)'(i);
    assign adm_here = adm_idx == (KW+1)'(i);

    // counter is reset only at power-on, never by a session start
    // unblock wins over a decrement landing in the same cycle
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        tries_reg[i] <= `PVR_TRIES_INIT;
      end else if (adm_here && unblock) begin
        tries_reg[i] <= `PVR_TRIES_INIT;
      end else if (cmd_here && hit) begin
        tries_reg[i] <= `PVR_TRIES_INIT;
      end else if (cmd_here && miss) begin
        tries_reg[i] <= tries_dec;
      end
    end

    // one flag per pin, not per channel, so every channel sees it
    // a success in the session-start cycle still counts
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        verified_reg[i] <= 1'b0;
      end else if (cmd_here && hit) begin
        verified_reg[i] <= 1'b1;
      end else if (session_start || (cmd_here && miss) || (adm_here && unblock)) begin
        verified_reg[i] <= 1'b0;
      end
    end

    // disable state and reference value from the administration port
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        disabled_reg[i] <= 1'b0;
        ref_mem[i] <= 64'h0;
      end else if (adm_here) begin
        if (dis_set) begin
          disabled_reg[i] <= 1'b1;
        end else if (dis_clr) begin
          disabled_reg[i] <= 1'b0;
        end
        if (ref_we) begin
          ref_mem[i] <= ref_pin;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // access check

  // a disabled pin passes; otherwise verified and not blocked
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      acc_ok <= 1'b0;
    end else begin
      acc_ok <= acc_req && (disabled_reg[acc_idx] ||
        (verified_reg[acc_idx] && tries_reg[acc_idx] != `PVR_TRIES_NONE));
    end
  end

endmodule // pvr_card
`default_nettype wire

// ===== hw/pvr_term.sv
// terminal end: builds verify commands and collects status words
`timescale 1ns/1ps
`default_nettype none
`include "pvr_params.svh"

module pvr_term (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // link to card
  pvr_if.term lk,
  // user request
  input wire logic go,
  input wire logic query,
  input wire logic [1:0] channel,
  input wire logic [7:0] p2,
  input wire logic [63:0] pin,
  // user answer
  output logic busy,
  output logic done,
  output logic [15:0] sw_out
);

  pvr_pkg::pvr_term_state_t state_reg;
  logic [103:0] tx_reg;
  logic [3:0] left_reg;
  logic byte_valid_reg;
  logic byte_last_reg;

  ////////////////////////////////////////////////////////////////////////
  // sequencing: one byte per cycle, then wait for the status word

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= pvr_pkg::PVR_TS_IDLE;
      tx_reg <= 104'h0;
      left_reg <= 4'h0;
    end else begin
      unique case (state_reg)
        pvr_pkg::PVR_TS_IDLE: begin
          if (go) begin
            state_reg <= pvr_pkg::PVR_TS_SEND;
            // P1 fixed, no Le; query leaves out Lc and data
            tx_reg <= {`PVR_CLA_BASE | {6'h00, channel}, `PVR_INS_VERIFY,
              `PVR_P1_VERIFY, p2, `PVR_LC_PIN, pin};
            left_reg <= query ? `PVR_HDR_BYTES : `PVR_FULL_BYTES;
          end
        end
        pvr_pkg::PVR_TS_SEND: begin
          tx_reg <= {tx_reg[95:0], 8'h00};
          left_reg <= left_reg - 4'h1;
          if (left_reg == 4'h1) begin
            state_reg <= pvr_pkg::PVR_TS_WAIT;
          end
        end
        pvr_pkg::PVR_TS_WAIT: begin
          if (lk.sw_valid) begin
            state_reg <= pvr_pkg::PVR_TS_IDLE;
          end
        end
        default: state_reg <= pvr_pkg::PVR_TS_IDLE;
      endcase
    end
  end

  // link outputs registered so they line up with data_reg
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      byte_valid_reg <= 1'b0;
      byte_last_reg <= 1'b0;
    end else begin
      byte_valid_reg <= state_reg == pvr_pkg::PVR_TS_SEND;
      byte_last_reg <= state_reg == pvr_pkg::PVR_TS_SEND && left_reg == 4'h1;
    end
  end

  logic [7:0] data_reg;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      data_reg <= 8'h00;
    end else begin
      data_reg <= tx_reg[103:96];
    end
  end

  assign lk.byte_valid = byte_valid_reg;
  assign lk.byte_last = byte_last_reg;
  assign lk.byte_data = data_reg;

  // user side answer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy <= 1'b0;
      done <= 1'b0;
      sw_out <= 16'h0000;
    end else begin
      done <= state_reg == pvr_pkg::PVR_TS_WAIT && lk.sw_valid;
      busy <= (state_reg == pvr_pkg::PVR_TS_IDLE) ? go :
        !(state_reg == pvr_pkg::PVR_TS_WAIT && lk.sw_valid);
      if (state_reg == pvr_pkg::PVR_TS_WAIT && lk.sw_valid) begin
        sw_out <= lk.sw;
      end
    end
  end

endmodule // pvr_term
`default_nettype wire

// ===== verification/pvr_link_sva.sv
// assertions on the terminal-to-card command link
`timescale 1ns/1ps
`default_nettype none
module pvr_link_sva (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // link signals
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic byte_last,
  input wire logic sw_valid,
  input wire logic [15:0] sw
);
  logic [3:0] pos_reg;
  logic full_reg;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////
  // byte position in command; full_reg marks a 13 byte command
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pos_reg <= 4'h0;
      full_reg <= 1'b0;
    end else if (byte_valid) begin
      pos_reg <= byte_last ? 4'h0 : pos_reg + 4'h1;
      full_reg <= byte_last ? (pos_reg == 4'hc) : full_reg;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // answer timing and holding
  answer_time_a: assert property (byte_valid && byte_last |=> !sw_valid ##1 sw_valid)
    else $error("status word not two cycles after last byte");
  sw_hold_a: assert property (!sw_valid |-> $stable(sw))
    else $error("status word moved without a valid strobe");
  // header coding sent by the terminal
  ins_code_a: assert property (byte_valid && pos_reg == 4'h1 |-> byte_data == 8'h20)
    else $error("wrong instruction byte");
  p1_zero_a: assert property (byte_valid && pos_reg == 4'h2 |-> byte_data == 8'h00)
    else $error("P1 not zero");
  lc_code_a: assert property (byte_valid && pos_reg == 4'h4 |-> byte_data == 8'h08)
    else $error("Lc not eight");
  last_pos_a: assert property (byte_valid && byte_last |-> pos_reg == 4'h3 || pos_reg == 4'hc)
    else $error("command length neither 4 nor 13");
  // retry reporting
  retry_range_a: assert property (sw_valid && sw[15:4] == 12'h63c |-> sw[3:0] <= 4'h3)
    else $error("retry count above three");
  wrong_pin_a: assert property (sw_valid && full_reg && sw[15:4] == 12'h63c |-> sw[3:0] != 4'h3)
    else $error("failed compare left counter full");
  blocked_a: assert property (sw_valid && sw == 16'h6983 |-> full_reg)
    else $error("blocked answer to a command without data");
  // main outcomes seen
  cover property (sw_valid && sw == 16'h6983);
  cover property (sw_valid && sw == 16'h63c0);
  cover property (sw_valid && sw == 16'h9000);
endmodule // pvr_link_sva
`default_nettype wire

// ===== verification/pin_verify_retry_logic_tb.sv
// self-checking bench: terminal and card joined by the link
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin mismatches++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module pin_verify_retry_logic_tb;
  localparam logic [63:0] REF = 64'h0123456789abcdef;
  localparam logic [63:0] BADL = REF ^ 64'h1;
  localparam logic [63:0] BADH = REF ^ 64'h8000000000000000;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic go = 1'b0;
  logic query = 1'b0;
  logic [1:0] channel = 2'h0;
  logic [7:0] p2 = 8'h00;
  logic [63:0] pin = 64'h0;
  logic busy, done, acc_ok;
  logic [15:0] sw_out;
  logic session_start = 1'b0, ref_we = 1'b0, dis_set = 1'b0, dis_clr = 1'b0, unblock = 1'b0;
  logic [1:0] adm_idx = 2'h0;
  logic [1:0] acc_idx = 2'h0;
  logic acc_req = 1'b0;
  int mismatches = 0;
  int comparisons = 0;
  ////////////////////////////////////////////////////////////////////////////
  pvr_if lk_if ();
  pvr_term pvr_term_inst (.clk(clk), .nrst(nrst), .lk(lk_if.term), .go(go), .query(query),
    .channel(channel), .p2(p2), .pin(pin), .busy(busy), .done(done), .sw_out(sw_out));
  pvr_card #(.KW(1)) pvr_card_inst (.clk(clk), .nrst(nrst), .lk(lk_if.card),
    .session_start(session_start), .adm_idx(adm_idx), .ref_we(ref_we), .ref_pin(REF),
    .dis_set(dis_set), .dis_clr(dis_clr), .unblock(unblock), .acc_req(acc_req),
    .acc_idx(acc_idx), .acc_ok(acc_ok));
  pvr_link_sva pvr_link_sva_inst (.clk(clk), .nrst(nrst), .byte_valid(lk_if.byte_valid),
    .byte_data(lk_if.byte_data), .byte_last(lk_if.byte_last), .sw_valid(lk_if.sw_valid),
    .sw(lk_if.sw));
  // 100 MHz clock
  always #5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // one command through the terminal, bounded wait for done, then compare
  task automatic vc(input logic q, input logic [1:0] ch, input logic [7:0] p,
                    input logic [63:0] v, input logic [15:0] exp_sw);
    int n;
    @(posedge clk);
    go <= 1'b1;
    query <= q;
    channel <= ch;
    p2 <= p;
    pin <= v;
    @(posedge clk);
    go <= 1'b0;
    #1;
    `CHK(busy, 1'b1)
    for (n = 0; n < 40 && done !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    // a missing answer counts as a mismatch, not a silent pass
    `CHK(done, 1'b1)
    `CHK(busy, 1'b0)
    `CHK(sw_out, exp_sw)
  endtask
  // admin pulse: {session_start, ref_we, dis_set, dis_clr, unblock}
  task automatic adm(input logic [4:0] k, input logic [1:0] i);
    @(posedge clk);
    {session_start, ref_we, dis_set, dis_clr, unblock} <= k;
    adm_idx <= i;
    @(posedge clk);
    {session_start, ref_we, dis_set, dis_clr, unblock} <= 5'h00;
  endtask
  // access check, answer lands on the edge that takes the request
  task automatic acc(input logic [1:0] i, input logic e);
    @(posedge clk);
    acc_req <= 1'b1;
    acc_idx <= i;
    @(posedge clk);
    acc_req <= 1'b0;
    #1;
    `CHK(acc_ok, e)
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // three failures across two sessions, block, then unblock
  task automatic t_count();
    vc(1'b1, 2'h0, 8'h01, 64'h0, 16'h63c3);
    vc(1'b0, 2'h0, 8'h01, BADL, 16'h63c2);
    vc(1'b1, 2'h1, 8'h01, 64'h0, 16'h63c2);
    vc(1'b0, 2'h3, 8'h01, BADH, 16'h63c1);
    adm(5'h10, 2'h1);
    vc(1'b0, 2'h2, 8'h01, BADL, 16'h63c0);
    vc(1'b0, 2'h0, 8'h01, REF, 16'h6983);
    vc(1'b1, 2'h0, 8'h01, 64'h0, 16'h63c0);
    acc(2'h1, 1'b0);
    adm(5'h01, 2'h1);
    vc(1'b1, 2'h0, 8'h01, 64'h0, 16'h63c3);
  endtask
  // success restores the counter and opens access on any channel
  task automatic t_restore();
    vc(1'b0, 2'h0, 8'h01, BADL, 16'h63c2);
    vc(1'b0, 2'h1, 8'h01, REF, 16'h9000);
    vc(1'b1, 2'h2, 8'h01, 64'h0, 16'h63c3);
    acc(2'h1, 1'b1);
    acc(2'h3, 1'b0);
    adm(5'h10, 2'h0);
    acc(2'h1, 1'b0);
  endtask
  // disabled pin: access open, no compare, query still answers
  task automatic t_disabled();
    adm(5'h04, 2'h2);
    acc(2'h2, 1'b1);
    vc(1'b0, 2'h0, 8'h80, BADL, 16'h6984);
    vc(1'b1, 2'h0, 8'h80, 64'h0, 16'h63c3);
    adm(5'h02, 2'h2);
    acc(2'h2, 1'b0);
  endtask
  // qualifier coding: reserved bits, key number, class bit
  task automatic t_p2();
    vc(1'b0, 2'h0, 8'h41, REF, 16'h6a86);
    vc(1'b0, 2'h0, 8'h21, REF, 16'h6a86);
    vc(1'b1, 2'h0, 8'h03, 64'h0, 16'h6a88);
    vc(1'b0, 2'h0, 8'h81, BADL, 16'h63c2);
    vc(1'b1, 2'h0, 8'h01, 64'h0, 16'h63c3);
    vc(1'b1, 2'h0, 8'h81, 64'h0, 16'h63c2);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    adm(5'h08, 2'h1);
    adm(5'h08, 2'h2);
    adm(5'h08, 2'h3);
    t_count();
    t_restore();
    t_disabled();
    t_p2();
    give_verdict();
  end
  // watchdog, about seventeen times the expected run
  initial begin
    #50000;
    mismatches++;
    give_verdict();
  end
endmodule // pin_verify_retry_logic_tb
`default_nettype wire
